// ===== rbs_pkg.sv
package rbs_pkg;

    // ****************************************
    // Instruction encodings
    // ****************************************
    localparam logic [9:0] RBS_OP_INTERRUPT_RETURN = 10'h046;
    localparam logic [9:0] RBS_OP_RETURN_SKIP = 10'h045;
    localparam logic [9:0] RBS_OP_CLEAR_HIGH_REF = 10'h058;
    localparam logic [7:0] RBS_OP_BIT_SET_HI = 8'h17;
    localparam int RBS_BIT_SEL_W = 2;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int RBS_PC_W = 14;
    localparam int RBS_SP_W = 3;
    localparam int RBS_DP_W = 7;
    localparam int RBS_TAB_W = 10;
    localparam int RBS_TAB_LOW_W = 8;
    localparam logic [RBS_SP_W-1:0] RBS_SP_RESET = 3'h7;
    localparam logic [RBS_SP_W-1:0] RBS_SP_STEP = 3'h1;
    localparam logic RBS_FLAG_RESET = 1'b0;
    localparam logic RBS_HIGH_ORDER_REF_ENABLE_FLAG_RESET = 1'b0;

    // Context saved when an interrupt is taken
    typedef struct packed {
        logic [2:0] dpX;
        logic [3:0] dpY;
        logic [1:0] dpZ;
        logic carryFlag;
        logic skipStatus;
        logic nopMode;
        logic [3:0] regA;
        logic [3:0] regB;
    } rbs_ctx_t;

    localparam rbs_ctx_t RBS_CTX_RESET = '0;

    // Memory write request
    typedef struct packed {
        logic valid;
        logic [RBS_DP_W-1:0] addr;
        logic [3:0] data;
    } rbs_memwr_t;

    typedef enum logic [2:0] {
        RBS_IDLE = 3'b001,
        RBS_RET1 = 3'b010,
        RBS_RET2 = 3'b100
    } rbs_state_t;

endpackage : rbs_pkg

// ===== rbs_bit_merge.sv
`timescale 1ns/100ps
module rbs_bit_merge
    import rbs_pkg::*;
(
    input wire logic [3:0] nibbleIn, // Current memory nibble
    input wire logic [RBS_BIT_SEL_W-1:0] bitSel, // Bit to set
    output logic [3:0] nibbleOut // Nibble with bit set
);
    always_comb
    begin
        nibbleOut = nibbleIn;
        nibbleOut[bitSel] = 1'b1;
    end
endmodule : rbs_bit_merge

// ===== rbs_return_bitset.sv
`timescale 1ns/100ps
// Summary of operation
// RQ1: Interrupt return pops PC, decrements SP, two cycles
// RQ2: Interrupt return restores saved core context
// RQ3: Return-and-skip pops PC, always skips next
// RQ4: Flag-clear zeroes high-order ref flag only
// RQ5: Flag low blocks upper two table bits
// RQ6: Bit-set writes one to bit j
module rbs_return_bitset
    import rbs_pkg::*;
(
    input wire logic core_clk, // Instruction clock
    input wire logic rst, // Async reset, active high
    input wire logic instValid, // Instruction word valid
    input wire logic [9:0] instWord, // Instruction word
    input wire logic [RBS_PC_W-1:0] stackTop, // return_stack entry at stack_pointer
    input wire logic [RBS_SP_W-1:0] stackPointerIn, // Current stack_pointer
    input wire logic [RBS_DP_W-1:0] dataPointer, // data_pointer address
    input wire logic [3:0] memNibble, // Nibble at data_pointer
    input wire logic setHighRefFlag, // Set flag from other logic
    input wire logic [9:0] tableData, // Fetched table ROM word
    input wire rbs_ctx_t savedCtx, // Context stored at interrupt
    output logic busy, // Second cycle of a two-cycle return
    output logic pcLoad, // Load PC pulse
    output logic [RBS_PC_W-1:0] pcValue, // New PC
    output logic spLoad, // Load stack_pointer pulse
    output logic [RBS_SP_W-1:0] stackPointerOut, // New stack_pointer
    output logic skipNext, // Skip following instruction
    output logic ctxRestore, // Restore context pulse
    output rbs_ctx_t ctxOut, // Restored context
    output rbs_memwr_t memWrite, // Memory write request
    output logic high_order_ref_enable_flag, // High-order ref enable
    output logic [9:0] tableResult // Table data to destination
);
    // ****************************************
    // Decode
    // ****************************************
    logic isIntRet;
    logic isRetSkip;
    logic isClrRef;
    logic isBitSet;
    logic [3:0] mergedNibble;
    rbs_state_t state;
    logic retIsInt;
    logic retStart;
    logic retEnd;
    logic [RBS_TAB_W-1:0] next_tableResult;

    assign isIntRet = instValid && (state == RBS_IDLE) && (instWord == RBS_OP_INTERRUPT_RETURN);
    assign isRetSkip = instValid && (state == RBS_IDLE) && (instWord == RBS_OP_RETURN_SKIP);
    assign isClrRef = instValid && (state == RBS_IDLE) && (instWord == RBS_OP_CLEAR_HIGH_REF);
    assign isBitSet = instValid && (state == RBS_IDLE)
        && (instWord[9:RBS_BIT_SEL_W] == RBS_OP_BIT_SET_HI);
    // Returns start only from idle; words during a return are dropped
    assign retStart = isIntRet || isRetSkip;
    assign retEnd = (state == RBS_RET1);

    rbs_bit_merge u_merge (
        .nibbleIn(memNibble),
        .bitSel(instWord[RBS_BIT_SEL_W-1:0]),
        .nibbleOut(mergedNibble)
    );

    // ****************************************
    // Return sequencing
    // ****************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= RBS_IDLE;
            retIsInt <= 1'b0;
        end
        else
        begin
            case (state)
                RBS_IDLE:
                begin
                    if (retStart)
                    begin
                        state <= RBS_RET1; // RQ1 RQ3
                        retIsInt <= isIntRet;
                    end
                end
                // Second return cycle ends the return
                RBS_RET1: state <= RBS_IDLE; // RQ1
                // Never entered; recovers to idle
                RBS_RET2: state <= RBS_IDLE;
                default: state <= RBS_IDLE;
            endcase
        end
    end

    // Busy marks the cycle in which new words are dropped
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            busy <= 1'b0;
        else
            busy <= retStart; // RQ1 RQ3
    end

    // ****************************************
    // Program counter load
    // ****************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pcLoad <= 1'b0;
            pcValue <= '0;
        end
        else
        begin
            pcLoad <= retStart; // RQ1 RQ3
            if (retStart)
                pcValue <= stackTop; // RQ1 RQ3
        end
    end

    // ****************************************
    // Stack pointer decrement
    // ****************************************
    // Pop follows the PC load by one cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            spLoad <= 1'b0;
            stackPointerOut <= RBS_SP_RESET;
        end
        else
        begin
            spLoad <= retEnd; // RQ1 RQ3
            if (retEnd)
                stackPointerOut <= stackPointerIn - RBS_SP_STEP; // RQ1 RQ3
        end
    end

    // ****************************************
    // Skip status
    // ****************************************
    // Held until the next accepted word
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            skipNext <= RBS_FLAG_RESET;
        else if (retEnd)
            skipNext <= !retIsInt; // RQ3
        else if (instValid && state == RBS_IDLE)
            skipNext <= RBS_FLAG_RESET;
    end

    // ****************************************
    // Context restore
    // ****************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctxRestore <= 1'b0;
        else
            ctxRestore <= retEnd && retIsInt; // RQ2
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctxOut <= RBS_CTX_RESET;
        else if (retEnd && retIsInt)
            ctxOut <= savedCtx; // RQ2
    end

    // ****************************************
    // High-order reference flag
    // ****************************************
    // Set from other logic wins over a clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            high_order_ref_enable_flag <= RBS_HIGH_ORDER_REF_ENABLE_FLAG_RESET;
        else if (setHighRefFlag)
            high_order_ref_enable_flag <= 1'b1;
        else if (isClrRef)
            high_order_ref_enable_flag <= 1'b0; // RQ4
    end

    // ****************************************
    // Table reference data
    // ****************************************
    // Upper bits are held at zero while the flag is clear
    always_comb
    begin
        next_tableResult = tableData;
        if (!high_order_ref_enable_flag)
            next_tableResult[RBS_TAB_W-1:RBS_TAB_LOW_W] = '0; // RQ5
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            tableResult <= '0;
        else
            tableResult <= next_tableResult; // RQ5
    end

    // ****************************************
    // Memory bit set
    // ****************************************
    // Address and data hold between writes
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            memWrite <= '0;
        else
        begin
            memWrite.valid <= isBitSet; // RQ6
            if (isBitSet)
            begin
                memWrite.addr <= dataPointer;
                memWrite.data <= mergedNibble; // RQ6
            end
        end
    end
endmodule : rbs_return_bitset

// ===== rbs_return_bitset_chk.sv
`timescale 1ns/100ps
module rbs_chk
    import rbs_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic instValid, // Valid
    input wire logic [9:0] instWord, // Opcode
    input wire logic [RBS_PC_W-1:0] stackTop, // Stack entry
    input wire logic [RBS_SP_W-1:0] stackPointerIn, // SP in
    input wire logic [RBS_DP_W-1:0] dataPointer, // Data pointer
    input wire logic [3:0] memNibble, // Nibble
    input wire logic setHighRefFlag, // Flag set
    input wire logic [9:0] tableData, // Table word
    input wire rbs_ctx_t savedCtx, // Saved context
    input wire logic busy, // Busy
    input wire logic pcLoad, // PC load
    input wire logic [RBS_PC_W-1:0] pcValue, // PC
    input wire logic spLoad, // SP load
    input wire logic [RBS_SP_W-1:0] stackPointerOut, // SP out
    input wire logic skipNext, // Skip
    input wire logic ctxRestore, // Restore
    input wire rbs_ctx_t ctxOut, // Context
    input wire rbs_memwr_t memWrite, // Write
    input wire logic high_order_ref_enable_flag, // Flag
    input wire logic [9:0] tableResult // Table
);
    // ****************************************
    // Return, bit-set, high-order flag and table checks
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic tk = instValid && !busy;
    wire logic [3:0] setNib = memNibble | (4'h1 << instWord[1:0]);
    sequence s_pop; pcLoad && pcValue == $past(stackTop); endsequence
    sequence s_sp; spLoad && stackPointerOut == $past(stackPointerIn) - RBS_SP_STEP; endsequence
    property p_rti; tk && instWord == RBS_OP_INTERRUPT_RETURN |=> s_pop ##1 s_sp ##0 !skipNext; endproperty
    a_rti: assert property (p_rti) else $error("interrupt return pop wrong");
    property p_busy; tk && (instWord == RBS_OP_INTERRUPT_RETURN || instWord == RBS_OP_RETURN_SKIP)
        |=> busy ##1 !busy; endproperty
    a_busy: assert property (p_busy) else $error("return not two cycles");
    property p_ctx; tk && instWord == RBS_OP_INTERRUPT_RETURN |=> ##1 ctxRestore && ctxOut == $past(savedCtx, 2);
    endproperty
    a_ctx: assert property (p_ctx) else $error("context not restored");
    property p_rts; tk && instWord == RBS_OP_RETURN_SKIP |=> s_pop ##1 s_sp ##0 skipNext; endproperty
    a_rts: assert property (p_rts) else $error("skip return wrong");
    property p_clr; tk && instWord == RBS_OP_CLEAR_HIGH_REF && !setHighRefFlag |=> !high_order_ref_enable_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_tab; !rst && !high_order_ref_enable_flag
        |=> tableResult == {2'h0, $past(tableData[7:0])}; endproperty
    a_tab: assert property (p_tab) else $error("upper table bits passed");
    property p_tabFull; !rst && high_order_ref_enable_flag |=> tableResult == $past(tableData); endproperty
    a_tabFull: assert property (p_tabFull) else $error("table word not passed");
    property p_set; setHighRefFlag |=> high_order_ref_enable_flag; endproperty
    a_set: assert property (p_set) else $error("flag set lost");
    property p_bit; tk && instWord[9:2] == RBS_OP_BIT_SET_HI |=> memWrite.valid && memWrite.data == $past(setNib)
        && memWrite.addr == $past(dataPointer);
    endproperty
    a_bit: assert property (p_bit) else $error("bit set write wrong");
endmodule : rbs_chk

// ===== rbs_return_bitset_tb.sv
`timescale 1ns/100ps
module rbs_return_bitset_tb;
    import rbs_pkg::*;
    // ****************************************
    // Stimulus and scoreboard
    // ****************************************
    logic core_clk = 0, rst = 1, instValid = 0, setHighRefFlag = 0;
    logic busy, pcLoad, spLoad, skipNext, ctxRestore, high_order_ref_enable_flag;
    logic [9:0] instWord = '0, tableData = '0, tableResult;
    logic [RBS_PC_W-1:0] stackTop = '0, pcValue;
    logic [RBS_SP_W-1:0] stackPointerIn = '0, stackPointerOut;
    logic [RBS_DP_W-1:0] dataPointer = '0;
    logic [3:0] memNibble = '0;
    rbs_ctx_t savedCtx = RBS_CTX_RESET, ctxOut;
    rbs_memwr_t memWrite;
    int seed = 32'h1fd4, n_fail = 0, n_compared = 0, cyc = 0;
    logic [31:0] q[$];
    rbs_return_bitset dut (.*);
    initial forever #50 core_clk = ~core_clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic op(input logic [9:0] w);
        logic [31:0] r;
        logic [31:0] c;
        r = $random(seed);
        c = $random(seed);
        @(posedge core_clk);
        instValid <= 1'b1;
        instWord <= w;
        stackTop <= r[13:0];
        stackPointerIn <= r[16:14];
        dataPointer <= r[23:17];
        memNibble <= r[27:24];
        savedCtx <= c[19:0];
        if (w[9:2] == RBS_OP_BIT_SET_HI) q.push_back({21'h0, r[23:17], r[27:24] | (4'h1 << w[1:0])});
        else if (w != RBS_OP_CLEAR_HIGH_REF) q.push_back({18'h0, r[13:0]});
        if (w == RBS_OP_INTERRUPT_RETURN) q.push_back({12'h0, c[19:0]});
        if (w == RBS_OP_INTERRUPT_RETURN || w == RBS_OP_RETURN_SKIP)
            q.push_back({28'h0, w == RBS_OP_RETURN_SKIP, r[16:14] - 3'h1});
        @(posedge core_clk);
        instValid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : op
    always @(posedge core_clk) tableData <= 10'($random(seed));
    always @(negedge core_clk)
    begin
        if (pcLoad === 1'b1) chk(32'(pcValue), q.pop_front());
        if (ctxRestore === 1'b1) chk(32'(ctxOut), q.pop_front());
        if (spLoad === 1'b1) chk(32'({skipNext, stackPointerOut}), q.pop_front());
        if (memWrite.valid === 1'b1) chk(32'({memWrite.addr, memWrite.data}), q.pop_front());
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            n_fail++;
            end_sim;
        end
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            for (int j = 0; j < 4; j++) op({RBS_OP_BIT_SET_HI, 2'(j)});
            op(RBS_OP_INTERRUPT_RETURN);
            op(RBS_OP_RETURN_SKIP);
            @(posedge core_clk) setHighRefFlag <= 1'b1;
            @(posedge core_clk) setHighRefFlag <= 1'(k % 2);
            op(RBS_OP_CLEAR_HIGH_REF);
            @(negedge core_clk) chk(32'(high_order_ref_enable_flag), 32'(k % 2));
        end
        chk(32'(q.size()), 32'h0);
        end_sim;
    end
endmodule : rbs_return_bitset_tb
bind rbs_return_bitset rbs_chk u_chk (.*);
